// >>> rtl/coarse_phase_pkg.sv
// shared constants for the coarse phase window configuration block
package coarse_phase_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int ERR_W = 15;
  localparam int TRK_W = 14;
  localparam int LIM_W = 13;
  localparam logic [ADDR_W-1:0] CFG_OFS = 8'h74;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h75;
  localparam logic [ADDR_W-1:0] MASK_OFS = 8'h76;
  localparam logic [ADDR_W-1:0] STATE_OFS = 8'h77;
  localparam logic [DATA_W-1:0] CFG_RST = 8'he5;
  localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
  localparam int LOSS_EN_BIT = 7;
  localparam int WIDE_EN_BIT = 6;
  localparam int MULTI_BIT = 5;
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_SAT = 4'hc;
  localparam logic [LIM_W-1:0] LIM_MAX = 13'h1fff;
  localparam logic [LIM_W-1:0] LIM_ONE_UI = 13'h0001;
  localparam int EV_LOSS_SET = 0;
  localparam int EV_LOSS_CLR = 1;
  localparam int EV_W = 2;
endpackage

// >>> rtl/coarse_range_decode.sv
// range code to coarse tracking limit in UI
`timescale 1ns/1ps
module coarse_range_decode (
  input wire logic [3:0] code_i,    // coarse range code
  output logic [12:0] limit_o       // limit in UI, 2^(n+1)-1 saturating
);
  always_comb begin
    if (code_i >= coarse_phase_pkg::CODE_SAT) begin
      limit_o = coarse_phase_pkg::LIM_MAX;
    end else begin
      limit_o = 13'((14'h0002 << code_i) - 14'h0001);
    end
  end
endmodule

// >>> rtl/coarse_phase_window.sv
// coarse phase window configuration register and coarse phase-loss path
// Notes on behaviour
// - loss enable off: coarse detector never flags loss
// - loss enable on: flag when error exceeds limit
// - multi-cycle bit off clips loop error to 1UI
// - position still tracked wide when wide-range on
// - code n gives 2^(n+1)-1 UI, 12+ 8191
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module coarse_phase_window (
  input wire logic clk_i,                // 50 MHz system clock
  input wire logic sys_rst_i,            // async reset, active high
  input wire logic [7:0] addr_i,         // register address
  input wire logic [7:0] wdata_i,        // write data
  input wire logic wr_i,                 // write strobe
  input wire logic rd_i,                 // read strobe
  output logic [7:0] rdata_o,            // read data, cycle after rd_i
  input wire logic signed [14:0] phase_err_i, // raw coarse phase error, UI
  output logic signed [13:0] track_o,    // tracked input phase position, UI
  output logic signed [13:0] loop_err_o, // phase error fed to the loop, UI
  output logic phase_loss_o,             // coarse phase-loss indication
  output logic irq_o                     // level interrupt
);
  logic [7:0] cfg_ff, nxt_cfg;
  logic [1:0] stat_ff, nxt_stat;
  logic [1:0] mask_ff, nxt_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic signed [13:0] track_ff, nxt_track;
  logic signed [13:0] loop_ff, nxt_loop;
  logic loss_ff, nxt_loss;
  logic [12:0] range_lim;
  logic [12:0] eff_lim;
  logic [14:0] err_mag;
  logic [1:0] ev;
  logic loss_en, wide_en, multi_en;

  assign loss_en = cfg_ff[coarse_phase_pkg::LOSS_EN_BIT];
  assign wide_en = cfg_ff[coarse_phase_pkg::WIDE_EN_BIT];
  assign multi_en = cfg_ff[coarse_phase_pkg::MULTI_BIT];

  coarse_range_decode u_dec (
    .code_i (cfg_ff[coarse_phase_pkg::CODE_LSB +: coarse_phase_pkg::CODE_W]),
    .limit_o (range_lim)
  );

  // abs of the most negative value still fits as an unsigned 15-bit count
  assign err_mag = phase_err_i[14] ? 15'(-phase_err_i) : 15'(phase_err_i);
  // without the wide detector the window is a single UI
  assign eff_lim = wide_en ? range_lim : coarse_phase_pkg::LIM_ONE_UI;

  always_comb begin
    // position clamped to the active window
    if (err_mag > {2'b00, eff_lim}) begin
      nxt_track = phase_err_i[14] ? -$signed({1'b0, eff_lim}) : $signed({1'b0, eff_lim});
    end else begin
      nxt_track = 14'(phase_err_i);
    end
    if (multi_en) begin
      nxt_loop = nxt_track;
    end else if (nxt_track > 14'sd1) begin
      nxt_loop = 14'sd1;
    end else if (nxt_track < -14'sd1) begin
      nxt_loop = -14'sd1;
    end else begin
      nxt_loop = nxt_track;
    end
    nxt_loss = loss_en && (err_mag > {2'b00, range_lim});
  end

  assign ev[coarse_phase_pkg::EV_LOSS_SET] = nxt_loss && !loss_ff;
  assign ev[coarse_phase_pkg::EV_LOSS_CLR] = !nxt_loss && loss_ff;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_rdata = 8'h00;
    if (wr_i && addr_i == coarse_phase_pkg::CFG_OFS) begin
      nxt_cfg = wdata_i;
    end
    if (wr_i && addr_i == coarse_phase_pkg::MASK_OFS) begin
      nxt_mask = wdata_i[1:0];
    end
    if (wr_i && addr_i == coarse_phase_pkg::STAT_OFS) begin
      nxt_stat = stat_ff & ~wdata_i[1:0];
    end
    // a new event beats a simultaneous clear
    nxt_stat = nxt_stat | ev;
    if (rd_i) begin
      unique case (addr_i)
        coarse_phase_pkg::CFG_OFS: nxt_rdata = cfg_ff;
        coarse_phase_pkg::STAT_OFS: nxt_rdata = {6'h00, stat_ff};
        coarse_phase_pkg::MASK_OFS: nxt_rdata = {6'h00, mask_ff};
        coarse_phase_pkg::STATE_OFS: nxt_rdata = {7'h00, loss_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_ff <= coarse_phase_pkg::CFG_RST;
      mask_ff <= coarse_phase_pkg::MASK_RST[1:0];
      stat_ff <= 2'h0;
      rdata_ff <= 8'h00;
      track_ff <= 14'sh0000;
      loop_ff <= 14'sh0000;
      loss_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
      rdata_ff <= nxt_rdata;
      track_ff <= nxt_track;
      loop_ff <= nxt_loop;
      loss_ff <= nxt_loss;
    end
  end

  assign rdata_o = rdata_ff;
  assign track_o = track_ff;
  assign loop_err_o = loop_ff;
  assign phase_loss_o = loss_ff;
  assign irq_o = |(stat_ff & mask_ff);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  loss_disabled_a: assert property (!loss_en |=> !phase_loss_o)
    else $error("phase loss raised while coarse loss disabled");
  loss_declared_a: assert property (
    loss_en && err_mag > {2'b00, range_lim} |=> phase_loss_o)
    else $error("phase loss missed beyond coarse limit");
  loss_within_a: assert property (
    err_mag <= {2'b00, range_lim} |=> !phase_loss_o)
    else $error("phase loss raised inside coarse limit");
  loop_clip_a: assert property (
    !multi_en |=> (loop_err_o <= 14'sd1 && loop_err_o >= -14'sd1))
    else $error("loop error not clipped to one UI");
  loop_multi_a: assert property (multi_en |=> loop_err_o == track_o)
    else $error("loop error differs from coarse result");
  track_wide_a: assert property (
    wide_en && !multi_en && err_mag <= {2'b00, range_lim}
    |=> track_o == 14'($past(phase_err_i)))
    else $error("position not tracked while multi-cycle off");
  range_map_a: assert property (
    (cfg_ff[3:0] >= 4'hc |-> range_lim == 13'h1fff)
    and (cfg_ff[3:0] == 4'h0 |-> range_lim == 13'h0001)
    and (cfg_ff[3:0] == 4'hb |-> range_lim == 13'h0fff))
    else $error("range code maps to wrong limit");
  wide_off_a: assert property (
    !wide_en |=> (track_o <= 14'sd1 && track_o >= -14'sd1))
    else $error("drift tracked with wide detector off");
  irq_level_a: assert property (
    |(ev & mask_ff) && !(wr_i && addr_i == coarse_phase_pkg::MASK_OFS) |=> irq_o)
    else $error("interrupt level missed an unmasked event");
  irq_clear_a: assert property (
    wr_i && addr_i == coarse_phase_pkg::STAT_OFS && wdata_i[1:0] == 2'b11 && ev == 2'b00
    |=> !irq_o)
    else $error("interrupt still high after full status clear");

  // per status bit; an event in the clearing cycle must survive the clear
  for (genvar b = 0; b < coarse_phase_pkg::EV_W; b++) begin : g_stat
    stat_set_a: assert property (ev[b] |=> stat_ff[b])
      else $error("status bit missed its event");
    stat_hold_a: assert property (
      stat_ff[b] && !(wr_i && addr_i == coarse_phase_pkg::STAT_OFS && wdata_i[b])
      |=> stat_ff[b])
      else $error("status bit dropped without a clear");
    stat_clear_a: assert property (
      !ev[b] && wr_i && addr_i == coarse_phase_pkg::STAT_OFS && wdata_i[b] |=> !stat_ff[b])
      else $error("status bit survived its clear");
    stat_idle_a: assert property (!ev[b] && !stat_ff[b] |=> !stat_ff[b])
      else $error("status bit set with no event");
  end
  loss_rise_a: assert property (
    $rose(phase_loss_o) |-> stat_ff[coarse_phase_pkg::EV_LOSS_SET])
    else $error("loss rise not recorded");
  loss_fall_a: assert property (
    $fell(phase_loss_o) |-> stat_ff[coarse_phase_pkg::EV_LOSS_CLR])
    else $error("loss fall not recorded");
  read_data_a: assert property (
    rd_i && addr_i == coarse_phase_pkg::CFG_OFS |=> rdata_o == $past(cfg_ff))
    else $error("config readback wrong");
  read_stat_a: assert property (
    rd_i && addr_i == coarse_phase_pkg::STAT_OFS |=> rdata_o == {6'h00, $past(stat_ff)})
    else $error("status readback wrong");
  read_mask_a: assert property (
    rd_i && addr_i == coarse_phase_pkg::MASK_OFS |=> rdata_o == {6'h00, $past(mask_ff)})
    else $error("mask readback wrong");
  read_state_a: assert property (
    rd_i && addr_i == coarse_phase_pkg::STATE_OFS |=> rdata_o == {7'h00, $past(phase_loss_o)})
    else $error("loss state readback wrong");
  // unmapped reads and idle cycles must both leave the bus at zero
  read_unmap_a: assert property (
    rd_i && addr_i != coarse_phase_pkg::CFG_OFS && addr_i != coarse_phase_pkg::STAT_OFS
    && addr_i != coarse_phase_pkg::MASK_OFS && addr_i != coarse_phase_pkg::STATE_OFS
    |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data stood past its cycle");
  cfg_write_a: assert property (
    wr_i && addr_i == coarse_phase_pkg::CFG_OFS |=> cfg_ff == $past(wdata_i))
    else $error("config write lost");
  cfg_hold_a: assert property (
    !(wr_i && addr_i == coarse_phase_pkg::CFG_OFS) |=> $stable(cfg_ff))
    else $error("config changed without a write");
  mask_write_a: assert property (
    wr_i && addr_i == coarse_phase_pkg::MASK_OFS
    |=> {6'h00, mask_ff} == ($past(wdata_i) & 8'h03))
    else $error("mask write lost");
  track_clamp_a: assert property (
    wide_en && err_mag > {2'b00, range_lim}
    |=> track_o == 14'($past(range_lim)) || track_o == -14'($past(range_lim)))
    else $error("position not held at the window edge");
  range_mid_a: assert property (
    (cfg_ff[3:0] == 4'h1 |-> range_lim == 13'h0003)
    and (cfg_ff[3:0] == 4'h5 |-> range_lim == 13'h003f)
    and (cfg_ff[3:0] == 4'h9 |-> range_lim == 13'h03ff))
    else $error("mid range code maps to wrong limit");

  loss_seen_c: cover property (loss_en ##1 phase_loss_o ##1 !phase_loss_o);
  multi_big_c: cover property (multi_en && wide_en ##1 loop_err_o > 14'sd100);
  irq_seen_c: cover property (irq_o);
  clear_race_c: cover property (wr_i && addr_i == coarse_phase_pkg::STAT_OFS && |ev);
  stat_clear_c: cover property (|stat_ff ##1 stat_ff == 2'b00);
endmodule

// >>> testbench/tb_coarse_phase_window.sv
// self-checking bench for the coarse phase window block
`timescale 1ns/1ps
module tb_coarse_phase_window;
  logic clk_i, sys_rst_i, wr_i, rd_i, phase_loss_o, irq_o, loss_m;
  logic [7:0] addr_i, wdata_i, rdata_o, cfg_m, mask_m, stat_m, exp_rd;
  logic signed [14:0] phase_err_i;
  logic signed [13:0] track_o, loop_err_o, exp_t, exp_l;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h938f;
  int cycles = 0;

  coarse_phase_window uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .phase_err_i(phase_err_i), .track_o(track_o), .loop_err_o(loop_err_o),
    .phase_loss_o(phase_loss_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic int clamp(int v, int lim);
    return v > lim ? lim : (v < -lim ? -lim : v);
  endfunction

  task automatic chk(string name, logic [13:0] exp, logic [13:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // reference model; uses config as held before the edge, like the design
  always @(posedge clk_i or posedge sys_rst_i) begin : model
    int e, lim, t;
    logic nl;
    e = phase_err_i;
    lim = cfg_m[3:0] >= 12 ? 8191 : (2 << cfg_m[3:0]) - 1;
    nl = cfg_m[7] && (e > lim || e < -lim);
    t = cfg_m[6] ? clamp(e, lim) : clamp(e, 1);
    if (sys_rst_i) begin
      cfg_m <= coarse_phase_pkg::CFG_RST;
      {mask_m, stat_m, exp_rd, exp_t, exp_l, loss_m} <= '0;
    end else begin
      exp_t <= 14'(t);
      exp_l <= 14'(cfg_m[5] ? t : clamp(t, 1));
      loss_m <= nl;
      // a new event wins over a clear in the same cycle
      stat_m <= (stat_m & ~((wr_i && addr_i == 8'h75) ? wdata_i : 8'h00))
        | {6'h00, loss_m & !nl, nl & !loss_m};
      if (wr_i && addr_i == 8'h74) cfg_m <= wdata_i;
      if (wr_i && addr_i == 8'h76) mask_m <= wdata_i & 8'h03;
      exp_rd <= !rd_i ? 8'h00 : addr_i == 8'h74 ? cfg_m : addr_i == 8'h75 ? stat_m
        : addr_i == 8'h76 ? mask_m : addr_i == 8'h77 ? {7'h00, loss_m} : 8'h00;
    end
  end

  always @(negedge clk_i) begin
    cycles++;
    if (!sys_rst_i) begin
      chk("track", exp_t, track_o);
      chk("loop", exp_l, loop_err_o);
      chk("loss", 14'(loss_m), 14'(phase_loss_o));
      chk("irq", 14'(|(stat_m & mask_m)), 14'(irq_o));
      chk("rdata", 14'(exp_rd), 14'(rdata_o));
    end
    if (cycles > 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin : stim
    int r, op;
    sys_rst_i = 1'b1;
    {wr_i, rd_i, addr_i, wdata_i, phase_err_i} = '0;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      r = $random(seed);
      // wide spread of magnitudes so every range code sees both sides
      phase_err_i <= 15'(r >>> (17 + (r & 15)));
      r = $random(seed);
      op = r & 7;
      wr_i <= op < 3;
      rd_i <= op == 3;
      addr_i <= op < 3 ? 8'h74 + 8'(op) : 8'h73 + 8'((r >> 4) & 7);
      wdata_i <= op == 0 ? {4'(r >> 8), 4'(i >> 4)} : 8'(r >> 8);
    end
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    close_out();
  end
endmodule
